//--- verilog/sfm_pkg.sv
// Constants shared by the supply fault monitor
package sfm_pkg;
    // Clock and qualify timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int QUALIFY_STEP_NS = 250;
    localparam int QUALIFY_STEP_CYCLES = (QUALIFY_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Threshold code arithmetic, millivolts
    localparam int THRESHOLD_BASE_MV = 1;
    localparam int THRESHOLD_STEP_MV = 1;
    localparam int CODE_WIDTH = 7;
    localparam int QUAL_WIDTH = 3;
    localparam int COUNT_WIDTH = 8;
    localparam int PRESCALE_WIDTH = 2;
    localparam logic [COUNT_WIDTH-1:0] COUNT_MAX = 8'hFF;
    // Fault index positions
    localparam int FAULT_OCP = 0;
    localparam int FAULT_UVP = 1;
    localparam int FAULT_UVN = 2;
    localparam int NUM_FAULTS = 3;
    // Reset values
    localparam logic NOMINAL_VOLTAGE_RESET = 1'h0;
    localparam logic [PRESCALE_WIDTH-1:0] PRESCALE_RESET = 2'h0;
    // Interval timer states
    typedef enum logic [1:0] {
        SFM_TMR_IDLE,
        SFM_TMR_RUN,
        SFM_TMR_DONE
    } sfm_tmr_state_t;
endpackage : sfm_pkg

//--- verilog/sfm_qualifier.sv
// Comparator qualifier: timer restarted on every deassertion
`timescale 1ns/1ns
`default_nettype none
module sfm_qualifier
    import sfm_pkg::*;
(
    input wire logic sys_clk_i, // System clock
    input wire logic reset_i, // Synchronous reset
    input wire logic [QUAL_WIDTH-1:0] qualify_code_i, // Multiple of 250 ns
    input wire logic comparator_i, // Synchronised comparator level
    output logic valid_o // Held while qualified
);
    localparam int TOTAL_WIDTH = 12;
    logic [TOTAL_WIDTH-1:0] count;
    logic [TOTAL_WIDTH-1:0] target;

    // Code 0 is treated as one step: the multiple must be positive
    always_comb begin
        target = TOTAL_WIDTH'((qualify_code_i == 3'h0 ? 1 : int'(qualify_code_i))
                 * QUALIFY_STEP_CYCLES);
    end

    // Count while asserted, clear on release
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || !comparator_i) begin
            count <= '0;
            valid_o <= 1'b0;
        end else if (count >= target - TOTAL_WIDTH'(1)) begin
            valid_o <= 1'b1;
        end else begin
            count <= count + TOTAL_WIDTH'(1);
        end
    end
endmodule : sfm_qualifier
`default_nettype wire

//--- verilog/sfm_supply_fault_monitor.sv
// Supply fault monitor: overcurrent/undervoltage flags, actions, interval timer
`timescale 1ns/1ns
`default_nettype none
module sfm_supply_fault_monitor
    import sfm_pkg::*;
(
    input wire logic sys_clk_i, // 100 MHz clock
    input wire logic reset_i, // Synchronous power-on reset
    // Configuration
    input wire logic [CODE_WIDTH-1:0] pos_overcurrent_threshold_code_i, // Trip code
    input wire logic [CODE_WIDTH-1:0] neg_overcurrent_threshold_code_i, // Trip code
    input wire logic [QUAL_WIDTH-1:0] pos_overcurrent_qualify_code_i, // n x 250 ns
    input wire logic nominal_voltage_select_i, // 0 = 12 V, 1 = 48 V
    input wire logic current_dependent_isolation_en_i, // Isolation mode bit
    input wire logic [NUM_FAULTS-1:0] pin_mask_i, // POS_OVERCURRENT_THRESHOLD_CODE, POSITIVE_UNDERVOLTAGE, NEGATIVE_UNDERVOLTAGE pin masks
    input wire logic [NUM_FAULTS-1:0] bridge_off_en_i, // Bridge action bits
    input wire logic [NUM_FAULTS-1:0] reverse_off_en_i, // Reverse action bits
    input wire logic [NUM_FAULTS-1:0] phase_latch_en_i, // Phase action bits
    input wire logic [NUM_FAULTS-1:0] flag_clear_i, // Write-1 pulses per flag
    // Interval timer control
    input wire logic enable_write_i, // Pulse: enable register written
    input wire logic interval_timer_enable_i, // Enable bit of that write
    input wire logic interval_timer_reset_i, // Pulse: reset bit written 1
    input wire logic timer_indication_clear_i, // Pulse: write 1 to indication
    input wire logic [PRESCALE_WIDTH-1:0] interval_timer_prescale_i, // Divide code
    // Analog comparator pins, asynchronous
    input wire logic pos_overcurrent_cmp_i, // Positive overcurrent comparator
    input wire logic neg_overcurrent_cmp_i, // Negative overcurrent comparator
    input wire logic neg_overcurrent_valid_i, // Filtered negative overcurrent
    input wire logic positive_undervoltage_cmp_i, // Valid positive undervoltage
    input wire logic negative_undervoltage_cmp_i, // Valid negative undervoltage
    input wire logic phase_off_i, // Phase switches currently off
    // Outputs
    output logic [CODE_WIDTH:0] pos_overcurrent_threshold_mv_o, // Trip level, mV
    output logic [CODE_WIDTH:0] neg_overcurrent_threshold_mv_o, // Trip level, mV
    output logic undervoltage_threshold_sel_o, // 1 = 48 V comparator set
    output logic [NUM_FAULTS-1:0] fault_flag_o, // POS_OVERCURRENT_THRESHOLD_CODE, POSITIVE_UNDERVOLTAGE, NEGATIVE_UNDERVOLTAGE flags
    output logic fault_indicator_pin_n_o, // Low while unmasked fault
    output logic bridge_off_o, // Bridge switch latched off
    output logic reverse_off_o, // Reverse switch off
    output logic phase_hold_off_o, // Phase switches held off
    output logic current_isolation_active_o, // Isolation mode live
    output logic [COUNT_WIDTH-1:0] interval_timer_count_o, // Saturating count
    output logic interval_timer_reset_flag_o // Timer reset indication
);
    // Three-stage synchronisers for asynchronous inputs
    localparam int NUM_SYNC = 6;
    logic [NUM_SYNC-1:0] raw_in;
    logic [NUM_SYNC-1:0] sync1;
    logic [NUM_SYNC-1:0] sync2;
    logic [NUM_SYNC-1:0] sync3;
    logic [NUM_SYNC-1:0] stable;

    assign raw_in = {phase_off_i, negative_undervoltage_cmp_i, positive_undervoltage_cmp_i,
                     neg_overcurrent_valid_i, neg_overcurrent_cmp_i, pos_overcurrent_cmp_i};

    genvar gi;
    generate
        for (gi = 0; gi < NUM_SYNC; gi++) begin : g_sync
            // A change counts only once stages two and three agree
            always_ff @(posedge sys_clk_i) begin
                if (reset_i) begin
                    sync1[gi] <= 1'b0;
                    sync2[gi] <= 1'b0;
                    sync3[gi] <= 1'b0;
                    stable[gi] <= 1'b0;
                end else begin
                    sync1[gi] <= raw_in[gi];
                    sync2[gi] <= sync1[gi];
                    sync3[gi] <= sync2[gi];
                    if (sync2[gi] == sync3[gi]) begin
                        stable[gi] <= sync3[gi];
                    end
                end
            end
        end
    endgenerate

    logic ocp_cmp;
    logic ocn_cmp;
    logic ocn_valid;
    logic phase_off;
    assign ocp_cmp = stable[0];
    assign ocn_cmp = stable[1];
    assign ocn_valid = stable[2];
    assign phase_off = stable[5];

    // Threshold arithmetic shared by both overcurrent codes
    function automatic logic [CODE_WIDTH:0] code_to_mv(input logic [CODE_WIDTH-1:0] code);
        code_to_mv = (CODE_WIDTH+1)'(THRESHOLD_STEP_MV * int'(code) + THRESHOLD_BASE_MV);
    endfunction : code_to_mv

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            pos_overcurrent_threshold_mv_o <= '0;
            neg_overcurrent_threshold_mv_o <= '0;
            undervoltage_threshold_sel_o <= NOMINAL_VOLTAGE_RESET;
        end else begin
            pos_overcurrent_threshold_mv_o <= code_to_mv(pos_overcurrent_threshold_code_i);
            neg_overcurrent_threshold_mv_o <= code_to_mv(neg_overcurrent_threshold_code_i);
            undervoltage_threshold_sel_o <= nominal_voltage_select_i;
        end
    end

    // Overcurrent qualifier
    logic ocp_valid;
    sfm_qualifier u_ocp_qualifier (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .qualify_code_i(pos_overcurrent_qualify_code_i),
        .comparator_i(ocp_cmp),
        .valid_o(ocp_valid)
    );

    logic [NUM_FAULTS-1:0] condition;
    assign condition = {stable[4], stable[3], ocp_valid};

    // Flags: set wins, clear only with condition gone
    logic [NUM_FAULTS-1:0] flag;
    generate
        for (gi = 0; gi < NUM_FAULTS; gi++) begin : g_flag
            always_ff @(posedge sys_clk_i) begin
                if (reset_i) begin
                    flag[gi] <= 1'b0;
                end else if (condition[gi]) begin
                    flag[gi] <= 1'b1;
                end else if (flag_clear_i[gi]) begin
                    flag[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Action terms; a flag stands for its latched fault state
    logic pin_low;
    logic bridge_trip;
    logic reverse_trip;
    logic phase_trip;
    assign pin_low = |(flag & ~pin_mask_i);
    assign bridge_trip = |(flag & bridge_off_en_i);
    assign reverse_trip = |(flag & reverse_off_en_i);
    assign phase_trip = |(flag & phase_latch_en_i);

    // Isolation mode: a reverse trip overrides it
    logic iso_live;
    assign iso_live = current_dependent_isolation_en_i && !reverse_trip;

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            fault_indicator_pin_n_o <= 1'b1;
            fault_flag_o <= '0;
            bridge_off_o <= 1'b0;
            reverse_off_o <= 1'b0;
            current_isolation_active_o <= 1'b0;
        end else begin
            fault_indicator_pin_n_o <= !pin_low;
            fault_flag_o <= flag;
            bridge_off_o <= bridge_trip;
            reverse_off_o <= reverse_trip || (iso_live && ocn_cmp);
            current_isolation_active_o <= iso_live;
        end
    end

    // Phase latch holds phases only if already off when the fault stands
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            phase_hold_off_o <= 1'b0;
        end else if (!phase_trip) begin
            phase_hold_off_o <= 1'b0;
        end else if (phase_off) begin
            phase_hold_off_o <= 1'b1;
        end
    end

    // Prescaler: ratios 1, 2, 4, 8
    logic [2:0] pre_count;
    logic [2:0] pre_limit;
    logic tick;
    sfm_tmr_state_t tmr_state;
    assign pre_limit = 3'((4'h1 << interval_timer_prescale_i) - 4'h1);
    assign tick = (pre_count == pre_limit);

    always_ff @(posedge sys_clk_i) begin
        if (reset_i || tmr_state != SFM_TMR_RUN || tick) begin
            pre_count <= '0;
        end else begin
            pre_count <= pre_count + 3'h1;
        end
    end

    // Interval timer; a filtered overcurrent of either polarity stops it
    logic fault_stop;
    logic enable_rise;
    assign fault_stop = ocp_valid || ocn_valid;
    assign enable_rise = enable_write_i && interval_timer_enable_i && !interval_timer_reset_i;

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            tmr_state <= SFM_TMR_IDLE;
            interval_timer_count_o <= '0;
        end else if (interval_timer_reset_i
                     || (enable_write_i && !interval_timer_enable_i)) begin
            tmr_state <= SFM_TMR_IDLE;
            interval_timer_count_o <= '0;
        end else begin
            case (tmr_state)
                SFM_TMR_IDLE: begin
                    if (enable_rise) begin
                        tmr_state <= SFM_TMR_RUN;
                        interval_timer_count_o <= '0;
                    end
                end
                SFM_TMR_RUN: begin
                    if (fault_stop) begin
                        tmr_state <= SFM_TMR_DONE;
                    end else if (tick && interval_timer_count_o != COUNT_MAX) begin
                        interval_timer_count_o <= interval_timer_count_o + 8'h01;
                    end
                end
                default: begin
                    // Result held until reset or new enable write
                    if (enable_rise) begin
                        tmr_state <= SFM_TMR_RUN;
                        interval_timer_count_o <= '0;
                    end
                end
            endcase
        end
    end

    // Timer reset indication: set wins over clear
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            interval_timer_reset_flag_o <= 1'b0;
        end else if (enable_rise) begin
            interval_timer_reset_flag_o <= 1'b1;
        end else if (timer_indication_clear_i) begin
            interval_timer_reset_flag_o <= 1'b0;
        end
    end
endmodule : sfm_supply_fault_monitor
`default_nettype wire

//--- tb/sfm_monitor_checker.sv
// Concurrent checks on the supply fault monitor ports
`timescale 1ns/1ns
`default_nettype none
module sfm_monitor_checker
    import sfm_pkg::*;
(
    input wire logic sys_clk_i, // Clock
    input wire logic reset_i, // Sync reset
    input wire logic [CODE_WIDTH-1:0] pos_overcurrent_threshold_code_i, // Trip code
    input wire logic nominal_voltage_select_i, // 12 or 48 V
    input wire logic [NUM_FAULTS-1:0] pin_mask_i, // Pin masks
    input wire logic [NUM_FAULTS-1:0] bridge_off_en_i, // Bridge actions
    input wire logic [NUM_FAULTS-1:0] flag_clear_i, // Clear pulses
    input wire logic enable_write_i, // Enable write
    input wire logic interval_timer_enable_i, // Enable data
    input wire logic interval_timer_reset_i, // Timer reset
    input wire logic [CODE_WIDTH:0] pos_overcurrent_threshold_mv_o, // Trip level
    input wire logic undervoltage_threshold_sel_o, // Select out
    input wire logic [NUM_FAULTS-1:0] fault_flag_o, // Flags
    input wire logic fault_indicator_pin_n_o, // Fault pin
    input wire logic bridge_off_o, // Bridge off
    input wire logic [COUNT_WIDTH-1:0] interval_timer_count_o, // Count
    input wire logic interval_timer_reset_flag_o // Indication
);
    // One clock domain; reset masks every check
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (reset_i);
    property p_thr;
        !$past(reset_i) |-> pos_overcurrent_threshold_mv_o ==
            {1'b0, $past(pos_overcurrent_threshold_code_i)} + 8'h01;
    endproperty
    a_thr: assert property (p_thr) else $error("trip level not code plus one");
    property p_sel;
        !$past(reset_i) |-> undervoltage_threshold_sel_o == $past(nominal_voltage_select_i);
    endproperty
    a_sel: assert property (p_sel) else $error("threshold select wrong");
    // Pin is judged only once flags and masks have settled
    property p_pin;
        fault_flag_o == $past(fault_flag_o) && $stable(pin_mask_i) && !$past(reset_i)
            |-> fault_indicator_pin_n_o == !(|(fault_flag_o & ~pin_mask_i));
    endproperty
    a_pin: assert property (p_pin) else $error("fault pin level wrong");
    property p_bridge;
        $past(|(fault_flag_o & bridge_off_en_i)) && |(fault_flag_o & bridge_off_en_i)
            |-> bridge_off_o;
    endproperty
    a_bridge: assert property (p_bridge) else $error("bridge not off");
    // A flag may only fall one or two cycles after its clear strobe
    property p_clr;
        $past(reset_i) || (($past(fault_flag_o) & ~fault_flag_o)
            & ~($past(flag_clear_i) | $past(flag_clear_i, 2))) == 3'h0;
    endproperty
    a_clr: assert property (p_clr) else $error("flag fell without clear");
    property p_ind;
        enable_write_i && interval_timer_enable_i && !interval_timer_reset_i
            |=> interval_timer_reset_flag_o;
    endproperty
    a_ind: assert property (p_ind) else $error("timer indication not set");
    property p_sat;
        interval_timer_count_o == COUNT_MAX && !enable_write_i && !interval_timer_reset_i
            |=> interval_timer_count_o == COUNT_MAX;
    endproperty
    a_sat: assert property (p_sat) else $error("count wrapped");
    property p_step;
        interval_timer_count_o != $past(interval_timer_count_o) && !$past(reset_i)
            |-> interval_timer_count_o == $past(interval_timer_count_o) + 8'h01
            || interval_timer_count_o == 8'h00;
    endproperty
    a_step: assert property (p_step) else $error("count jumped");
endmodule : sfm_monitor_checker
bind sfm_supply_fault_monitor sfm_monitor_checker i_checker (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .pos_overcurrent_threshold_code_i(pos_overcurrent_threshold_code_i),
    .nominal_voltage_select_i(nominal_voltage_select_i), .pin_mask_i(pin_mask_i),
    .bridge_off_en_i(bridge_off_en_i), .flag_clear_i(flag_clear_i),
    .enable_write_i(enable_write_i), .interval_timer_enable_i(interval_timer_enable_i),
    .interval_timer_reset_i(interval_timer_reset_i),
    .pos_overcurrent_threshold_mv_o(pos_overcurrent_threshold_mv_o),
    .undervoltage_threshold_sel_o(undervoltage_threshold_sel_o),
    .fault_flag_o(fault_flag_o), .fault_indicator_pin_n_o(fault_indicator_pin_n_o),
    .bridge_off_o(bridge_off_o), .interval_timer_count_o(interval_timer_count_o),
    .interval_timer_reset_flag_o(interval_timer_reset_flag_o)
);
`default_nettype wire

//--- tb/sfm_host_model.sv
// Host model: register write strobes for the fault monitor
`timescale 1ns/1ns
`default_nettype none
module sfm_host_model
    import sfm_pkg::*;
(
    input wire logic sys_clk_i, // System clock
    output logic [NUM_FAULTS-1:0] flag_clear_o, // Write-1 clear pulses
    output logic enable_write_o, // Enable register written
    output logic interval_timer_enable_o, // Enable data bit
    output logic interval_timer_reset_o // Timer reset written 1
);
    // Strobes idle until a write is asked for
    initial begin
        flag_clear_o = 3'h0;
        enable_write_o = 1'b0;
        interval_timer_enable_o = 1'b0;
        interval_timer_reset_o = 1'b0;
    end
    // Called just after an edge; strobe held for exactly one edge
    task automatic write_clear(input int idx);
        flag_clear_o <= 3'h1 << idx;
        @(posedge sys_clk_i);
        #1;
        flag_clear_o <= 3'h0;
    endtask : write_clear
    task automatic write_enable(input logic en);
        enable_write_o <= 1'b1;
        interval_timer_enable_o <= en;
        @(posedge sys_clk_i);
        #1;
        enable_write_o <= 1'b0;
    endtask : write_enable
    task automatic write_timer_reset();
        interval_timer_reset_o <= 1'b1;
        @(posedge sys_clk_i);
        #1;
        interval_timer_reset_o <= 1'b0;
    endtask : write_timer_reset
endmodule : sfm_host_model
`default_nettype wire

//--- tb/sfm_supply_fault_monitor_tb.sv
// Self-checking bench for the supply fault monitor
`timescale 1ns/1ns
`default_nettype none
module sfm_supply_fault_monitor_tb;
    import sfm_pkg::*;
    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [6:0] ocp_code = 7'h00;
    logic [2:0] qual_code = 3'h2;
    logic nom_sel = 1'b0;
    logic [2:0] mask = 3'h0, bridge_en = 3'h5, rev_en = 3'h2, phase_en = 3'h1;
    logic [1:0] prescale = 2'h0;
    logic ocp_cmp = 1'b0, uvp_cmp = 1'b0, uvn_cmp = 1'b0, phase_off = 1'b0;
    logic [2:0] clr, flags;
    logic ew, en, trst, uv_sel, pin_n, bridge, rev, phase_hold, ind;
    logic [7:0] thr_mv, count, ocn_mv, held;
    logic [6:0] ocn_code = 7'h00;
    logic iso_en = 1'b0, ind_clr = 1'b0, ocn_cmp = 1'b0, ocn_valid = 1'b0;
    logic iso_act;
    int err_count = 0;
    int num_checks = 0;
    always #5 sys_clk_i = ~sys_clk_i;
    sfm_host_model i_host (.sys_clk_i(sys_clk_i), .flag_clear_o(clr), .enable_write_o(ew),
        .interval_timer_enable_o(en), .interval_timer_reset_o(trst));
    // Every input is driven so that the isolation and timer-stop paths are exercised
    sfm_supply_fault_monitor i_dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
        .pos_overcurrent_threshold_code_i(ocp_code), .neg_overcurrent_threshold_code_i(ocn_code),
        .pos_overcurrent_qualify_code_i(qual_code), .nominal_voltage_select_i(nom_sel),
        .current_dependent_isolation_en_i(iso_en), .pin_mask_i(mask), .bridge_off_en_i(bridge_en),
        .reverse_off_en_i(rev_en), .phase_latch_en_i(phase_en), .flag_clear_i(clr),
        .enable_write_i(ew), .interval_timer_enable_i(en), .interval_timer_reset_i(trst),
        .timer_indication_clear_i(ind_clr), .interval_timer_prescale_i(prescale),
        .pos_overcurrent_cmp_i(ocp_cmp), .neg_overcurrent_cmp_i(ocn_cmp),
        .neg_overcurrent_valid_i(ocn_valid), .positive_undervoltage_cmp_i(uvp_cmp),
        .negative_undervoltage_cmp_i(uvn_cmp), .phase_off_i(phase_off),
        .pos_overcurrent_threshold_mv_o(thr_mv), .neg_overcurrent_threshold_mv_o(ocn_mv),
        .undervoltage_threshold_sel_o(uv_sel), .fault_flag_o(flags),
        .fault_indicator_pin_n_o(pin_n), .bridge_off_o(bridge), .reverse_off_o(rev),
        .phase_hold_off_o(phase_hold), .current_isolation_active_o(iso_act),
        .interval_timer_count_o(count), .interval_timer_reset_flag_o(ind));
    // Ends just past an edge so that outputs have settled
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : cyc
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out
    // Hang guard: the sequence needs under 1500 cycles
    initial begin
        #50000;
        err_count++;
        close_out();
    end
    initial begin
        cyc(2);
        reset_i <= 1'b0;
        cyc(2);
        chk({flags, pin_n}, 8'h01);
        // Code extremes and both supply settings
        for (int c = 0; c < 128; c += 127) begin
            ocp_code <= 7'(c);
            nom_sel <= c[0];
            cyc(2);
            chk(thr_mv, 8'(c + 1));
            chk(uv_sel, 8'(nom_sel));
        end
        // A pulse shorter than 2 x 250 ns must not qualify
        phase_off <= 1'b1;
        ocp_cmp <= 1'b1;
        cyc(40);
        ocp_cmp <= 1'b0;
        cyc(60);
        chk(flags, 8'h00);
        ocp_cmp <= 1'b1;
        cyc(45);
        chk(flags, 8'h00);
        cyc(20);
        chk({flags, pin_n, bridge, rev, phase_hold}, 8'h15);
        phase_off <= 1'b0;
        host_clear(0);
        chk({flags, phase_hold}, 8'h03);
        ocp_cmp <= 1'b0;
        cyc(8);
        host_clear(0);
        chk({flags, pin_n, bridge, phase_hold}, 8'h04);
        // Masked positive undervoltage, reverse action only
        mask <= 3'h2;
        phase_off <= 1'b1;
        uvp_cmp <= 1'b1;
        cyc(12);
        chk({flags, pin_n, bridge, rev, phase_hold}, 8'h2A);
        uvp_cmp <= 1'b0;
        phase_off <= 1'b0;
        cyc(8);
        host_clear(1);
        chk({flags, rev}, 8'h00);
        uvn_cmp <= 1'b1;
        cyc(12);
        chk({flags, pin_n, bridge, rev}, 8'h22);
        uvn_cmp <= 1'b0;
        cyc(8);
        host_clear(2);
        chk({flags, pin_n, bridge}, 8'h02);
        // Current-dependent isolation follows the negative comparator
        ocn_code <= 7'h7F;
        iso_en <= 1'b1;
        ocn_cmp <= 1'b1;
        cyc(8);
        chk(ocn_mv, 8'h80);
        chk({iso_act, rev}, 8'h03);
        ocn_cmp <= 1'b0;
        cyc(8);
        chk({iso_act, rev}, 8'h02);
        iso_en <= 1'b0;
        // Interval timer: saturate, stop, prescale, fault stop
        i_host.write_enable(1'b1);
        cyc(1);
        chk(ind, 8'h01);
        ind_clr <= 1'b1;
        cyc(1);
        ind_clr <= 1'b0;
        cyc(1);
        chk(ind, 8'h00);
        cyc(300);
        chk(count, 8'hFF);
        i_host.write_enable(1'b0);
        cyc(2);
        chk(count, 8'h00);
        prescale <= 2'h3;
        i_host.write_enable(1'b1);
        cyc(80);
        chk(8'(count >= 8'h09 && count <= 8'h0B), 8'h01);
        i_host.write_timer_reset();
        cyc(20);
        chk(count, 8'h00);
        prescale <= 2'h0;
        // A filtered negative overcurrent also stops the count
        i_host.write_enable(1'b1);
        cyc(20);
        ocn_valid <= 1'b1;
        cyc(8);
        held = count;
        chk(8'(count >= 8'h14 && count <= 8'h1E), 8'h01);
        cyc(10);
        chk(count, held);
        ocn_valid <= 1'b0;
        cyc(6);
        qual_code <= 3'h1;
        i_host.write_enable(1'b1);
        cyc(30);
        ocp_cmp <= 1'b1;
        cyc(80);
        chk(8'(count >= 8'h36 && count <= 8'h44), 8'h01);
        ocp_cmp <= 1'b0;
        cyc(8);
        host_clear(0);
        close_out();
    end
    task automatic host_clear(input int idx);
        i_host.write_clear(idx);
        cyc(4);
    endtask : host_clear
endmodule : sfm_supply_fault_monitor_tb
`default_nettype wire
